// *** logic/hpp_host_port.sv ***
`timescale 1ns/1ps
`include "hpp_regs.svh"
module hpp_host_port import hpp_pkg::*; #(
  parameter int CONV_CYCLES = `HPP_CONV_CYCLES,
  parameter int FIFO_DEPTH  = `HPP_FIFO_DEPTH
) (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic                   conversion_start_n,
  input  wire hpp_bus_ctl_t           bus_ctl,
  input  wire logic [`HPP_DATA_MSB:0] result_data_bus_in,
  output logic [`HPP_DATA_MSB:0]      result_data_bus_out,
  output logic                        result_data_bus_oe,
  output logic                        overrange_bit,
  output logic                        overrange_bit_oe,
  output logic                        busy_n,
  input  wire logic                   interface_variant_sel_a,
  input  wire logic                   interface_variant_sel_b,
  input  wire logic                   standby_request,
  input  wire logic                   light_sleep_request,
  output logic                        standby_active,
  output logic                        nap_active,
  input  wire hpp_result_t            core_result,
  output logic                        core_sample,
  output logic [`HPP_DATA_MSB:0]      offset_word
);
  localparam int CW = $clog2(CONV_CYCLES + 1);

  // one packed struct holds every flop; next_s is its copy
  typedef struct packed {
    hpp_state_t               st;
    logic [CW-1:0]            cnt;
    logic                     conversion_start_n_q;
    logic                     write_q;
    logic                     busy_n;
    logic                     sample;
    logic                     standby;
    logic                     nap;
    hpp_result_t              out_reg;
    logic [`HPP_DATA_MSB:0]   offset;
  } hpp_core_t;

  // busy idles high and both edge detectors sit at idle pin levels
  localparam hpp_core_t RESET_STATE = '{
    st:       HPP_IDLE,
    cnt:      '0,
    conversion_start_n_q: 1'b1,
    write_q:  1'b0,
    busy_n:   1'b1,
    sample:   1'b0,
    standby:  1'b0,
    nap:      1'b0,
    out_reg:  `HPP_RESULT_RST,
    offset:   `HPP_OFFSET_RST
  };

  hpp_core_t   s;
  hpp_core_t   next_s;
  logic        variant2;
  logic        conv_fall;
  logic        write_fall;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  hpp_result_t fifo_out_data;

  logic        power_down;
  logic        start_ok;
  logic        conv_last;
  logic        push_ok;
  logic        pop;
  logic        write_take;
  logic        read_sel;

  // sel_a alone or neither selects variant 1; sel_b selects variant 2
  // both selects decoded so every pin pattern has a defined meaning
  always_comb begin
    case ({interface_variant_sel_a, interface_variant_sel_b})
      2'h1:    variant2 = 1'b1;
      2'h3:    variant2 = 1'b1;
      default: variant2 = 1'b0;
    endcase
  end

  // start on falling edge
  // conversion_start_n_q resets high, so a start held low through reset counts as a fall on the first enabled clock
  assign conv_fall = s.conversion_start_n_q & ~conversion_start_n;

  // powered-down starts are dropped, not queued for later
  assign power_down = standby_request | light_sleep_request;
  assign start_ok   = conv_fall & ~power_down;
  // counter ends one short; the push cycle closes the conversion
  assign conv_last  = (s.cnt == CW'(CONV_CYCLES - 1));

  // latch on write falling edge
  // write_q resets low, so a strobe high through reset still has to fall once
  assign write_fall = s.write_q & ~bus_ctl.write;

  // write needs chip select; tied-low select works too
  assign write_take = write_fall & ~bus_ctl.cs_n;

  // fifo handshakes qualified once here
  assign fifo_in_valid = (s.st == HPP_PUSH);
  assign push_ok       = fifo_in_valid & fifo_in_ready;

  // variant 2 drains only on the next start edge
  // a refused start still drains, so a powered-down host can collect its result
  assign fifo_out_ready = variant2 ? conv_fall : 1'b1;
  assign pop            = fifo_out_valid & fifo_out_ready;

  // results wait here between end of conversion and output register load
  hpp_fifo #(
    .WIDTH ($bits(hpp_result_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (core_result),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    next_s          = s;
    next_s.conversion_start_n_q = conversion_start_n;
    next_s.write_q  = bus_ctl.write;
    next_s.sample   = 1'b0;
    next_s.standby  = standby_request;
    next_s.nap      = light_sleep_request;

    if (write_take) begin
      next_s.offset = result_data_bus_in;
    end

    // output register moves only on a pop
    if (pop) begin
      next_s.out_reg = fifo_out_data;
    end

    case (s.st)
      HPP_IDLE: begin
        // starts refused while powered down; a running conversion still ends
        if (start_ok) begin
          next_s.st     = HPP_CONV;
          next_s.cnt    = '0;
          next_s.busy_n = 1'b0;
          next_s.sample = 1'b1;
        end
      end
      HPP_CONV: begin
        // the core converts while this counter runs
        if (conv_last) begin
          next_s.st = HPP_PUSH;
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      HPP_PUSH: begin
        // full buffer holds busy low until the host drains it
        if (push_ok) begin
          if (variant2) begin
            next_s.st     = HPP_IDLE;
            next_s.busy_n = 1'b1;
          end else begin
            next_s.st = HPP_LATCH;
          end
        end
      end
      HPP_LATCH: begin
        // busy up with the output register load
        if (fifo_out_valid) begin
          next_s.st     = HPP_IDLE;
          next_s.busy_n = 1'b1;
        end
      end
      default: begin
        // an unreachable code falls back to the full reset state, clearing offset and output register
        next_s = RESET_STATE;
      end
    endcase
  end

  // clk_en low freezes the edge detectors too, so a slow fall is seen once
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= RESET_STATE;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // drive once select and read are low
  // released when either is high; never while writing
  assign read_sel            = ~bus_ctl.cs_n & ~bus_ctl.rd_n;
  assign result_data_bus_oe  = reset_n & read_sel & ~bus_ctl.write;
  // bit 11 is the most significant
  assign result_data_bus_out = s.out_reg.data;
  // overrange as a thirteenth data bit
  assign overrange_bit       = s.out_reg.overrange;
  assign overrange_bit_oe    = result_data_bus_oe;

  // busy leaves a flop so the host never sees a decode glitch
  assign busy_n              = s.busy_n;
  // one-clock pulse tells the core to hold its sample
  assign core_sample         = s.sample;
  // power outputs lag their requests by one clock
  assign standby_active      = s.standby;
  assign nap_active          = s.nap;
  assign offset_word         = s.offset;
endmodule

// *** logic/hpp_regs.svh ***
// Operation
// - standby request held high puts the device in standby.
// - light sleep request held high puts the device in nap.
// - bus driven with output register only after chip select and read fall.
// - offset word captured on the write strobe falling edge.
// - offset write only counts while chip select is asserted.
// - busy goes low after conversion start falls, stays low throughout.
// - variant 1: busy rises once result sits in output register.
// - variant 2: busy rises as soon as conversion completes.
// - variant 2: result latched at next conversion start falling edge.
// - data bus twelve bits, bit 11 most significant.
// - chip select, read and write steer the three-state data lines.
// - conversion begins on conversion start falling edge.
// - reset clears state machine, conversion and offset register.
// - thirteenth output bit flags overrange results.
`ifndef HPP_REGS_SVH
`define HPP_REGS_SVH
`define HPP_DATA_W      12
`define HPP_DATA_MSB    11
`define HPP_OFFSET_RST  12'h000
`define HPP_RESULT_RST  13'h0000
`define HPP_TCONV_NS    300
`define HPP_MCLK_MHZ    40
`define HPP_CONV_CYCLES ((`HPP_TCONV_NS * `HPP_MCLK_MHZ) / 1000)
`define HPP_FIFO_DEPTH  4
`endif

// *** logic/hpp_pkg.sv ***
package hpp_pkg;
  typedef struct packed {
    logic        overrange;
    logic [11:0] data;
  } hpp_result_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic write;
  } hpp_bus_ctl_t;

  typedef enum logic [1:0] {
    HPP_IDLE  = 2'b00,
    HPP_CONV  = 2'b01,
    HPP_PUSH  = 2'b10,
    HPP_LATCH = 2'b11
  } hpp_state_t;
endpackage

// *** logic/hpp_fifo.sv ***
`timescale 1ns/1ps
module hpp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } hpp_fifo_state_t;

  hpp_fifo_state_t s;
  hpp_fifo_state_t next_s;
  logic            push;
  logic            pop;

  assign in_ready  = (s.count != CW'(DEPTH));
  assign out_valid = (s.count != '0);
  assign out_data  = s.mem[s.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data;
      next_s.wr_ptr = (s.wr_ptr == AW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = (s.rd_ptr == AW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   next_s.count = s.count + 1'b1;
      2'b01:   next_s.count = s.count - 1'b1;
      default: next_s.count = s.count;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end
endmodule

// *** verif/hpp_core_model.sv ***
`timescale 1ns/1ps
module hpp_core_model import hpp_pkg::*; (
  input  logic        mclk,
  input  logic        reset_n,
  input  logic        core_sample,
  output hpp_result_t core_result
);
  // big step so the overrange bit toggles within a few samples
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      core_result <= 13'h0123;
    end else if (core_sample) begin
      core_result <= core_result + 13'h0801;
    end
  end
endmodule

// *** verif/hpp_host_port_checker.sv ***
`timescale 1ns/1ps
module hpp_host_port_checker import hpp_pkg::*; #(
  parameter int CONV_CYCLES = 12
) (
  input logic         mclk,
  input logic         reset_n,
  input logic         conversion_start_n,
  input hpp_bus_ctl_t bus_ctl,
  input logic [11:0]  result_data_bus_in,
  input logic [11:0]  result_data_bus_out,
  input logic         result_data_bus_oe,
  input logic         overrange_bit,
  input logic         busy_n,
  input logic         interface_variant_sel_b,
  input logic         standby_request,
  input logic         light_sleep_request,
  input logic         standby_active,
  input hpp_result_t  core_result,
  input logic         core_sample,
  input logic [11:0]  offset_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence start_taken;
    $fell(conversion_start_n) && busy_n && !standby_request && !light_sleep_request;
  endsequence
  read_drive_a: assert property (result_data_bus_oe == (!bus_ctl.cs_n && !bus_ctl.rd_n && !bus_ctl.write))
    else $error("data drive wrong");
  offset_load_a: assert property ($past(bus_ctl.write) && !bus_ctl.write && !bus_ctl.cs_n
    |=> offset_word == $past(result_data_bus_in)) else $error("offset not loaded");
  offset_keep_a: assert property (!($past(bus_ctl.write) && !bus_ctl.write && !bus_ctl.cs_n)
    |=> $stable(offset_word)) else $error("offset changed");
  standby_req_a: assert property (standby_request |=> standby_active) else $error("standby missed");
  busy_start_a: assert property (start_taken |=> !busy_n && core_sample) else $error("start missed");
  busy_hold_a: assert property ($fell(busy_n) |-> !busy_n [*3]) else $error("busy too short");
  v1_latch_a: assert property (!interface_variant_sel_b && $rose(busy_n)
    |-> {overrange_bit, result_data_bus_out} == core_result) else $error("result not latched");
  v2_hold_a: assert property (interface_variant_sel_b && !$fell(conversion_start_n)
    |=> $stable({overrange_bit, result_data_bus_out})) else $error("result moved early");
endmodule
bind hpp_host_port hpp_host_port_checker #(.CONV_CYCLES(CONV_CYCLES)) chk (.mclk, .reset_n, .conversion_start_n,
  .bus_ctl, .result_data_bus_in, .result_data_bus_out, .result_data_bus_oe, .overrange_bit, .busy_n,
  .interface_variant_sel_b, .standby_request, .light_sleep_request, .standby_active, .core_result,
  .core_sample, .offset_word);

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin $display("ERROR %s exp %h got %h", n, e, g); err_total++; end end
module tb_top import hpp_pkg::*; ;
  localparam int CONV = 2;
  logic         mclk = 1'b0;
  logic         reset_n = 1'b0;
  logic         conversion_start_n = 1'b1;
  logic         interface_variant_sel_a = 1'b1;
  logic         interface_variant_sel_b = 1'b0;
  logic         standby_request = 1'b0;
  logic         light_sleep_request = 1'b0;
  hpp_bus_ctl_t bus_ctl = 3'b110;
  logic [11:0]  host_d = 12'h000;
  logic [11:0]  result_data_bus_out, offset_word;
  logic         result_data_bus_oe, overrange_bit, overrange_bit_oe, busy_n;
  logic         standby_active, nap_active, core_sample;
  hpp_result_t  core_result;
  logic [12:0]  exp_res = 13'h0123, exp_reg = 13'h0000, pend = 13'h0000;
  logic [11:0]  exp_off = 12'h000;
  logic         pend_ok = 1'b0;
  int           err_total = 0, tests_run = 0, n;
  // the host sees its own value whenever the device is not driving
  wire  [11:0]  result_data_bus_in = result_data_bus_oe ? result_data_bus_out : host_d;
  always #12.5 mclk = ~mclk;
  hpp_host_port #(.CONV_CYCLES(CONV), .FIFO_DEPTH(4)) dut (.mclk, .reset_n, .clk_en(1'b1), .conversion_start_n,
    .bus_ctl, .result_data_bus_in, .result_data_bus_out, .result_data_bus_oe, .overrange_bit, .overrange_bit_oe,
    .busy_n, .interface_variant_sel_a, .interface_variant_sel_b, .standby_request, .light_sleep_request,
    .standby_active, .nap_active, .core_result, .core_sample, .offset_word);
  hpp_core_model core (.mclk, .reset_n, .core_sample, .core_result);
  task tick;
    @(posedge mclk);
    #1;
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic cs, input logic [11:0] d);
    bus_ctl.cs_n = cs;
    bus_ctl.write = 1'b1;
    host_d = d;
    tick;
    `CHK("offset_early", exp_off, offset_word)
    bus_ctl.write = 1'b0;
    tick;
    bus_ctl.cs_n = 1'b1;
    host_d = ~d;
    tick;
    if (!cs) exp_off = d;
    `CHK("offset", exp_off, offset_word)
  endtask
  task rd(input logic cs);
    bus_ctl.cs_n = cs;
    bus_ctl.rd_n = 1'b0;
    #2;
    `CHK("drive", !cs, result_data_bus_oe)
    `CHK("drive_ovr", !cs, overrange_bit_oe)
    if (!cs) `CHK("read", exp_reg, {overrange_bit, result_data_bus_out})
    tick;
    bus_ctl = 3'b110;
    // idle clock keeps the next task's strobes off this time step
    tick;
  endtask
  task conv(input logic run);
    conversion_start_n = 1'b0;
    tick;
    conversion_start_n = 1'b1;
    tick;
    `CHK("busy_fall", !run, busy_n)
    if (run) exp_res = exp_res + 13'h0801;
    // any start fall pops a waiting result, even a refused one
    if (interface_variant_sel_b && pend_ok) exp_reg = pend;
    pend_ok = 1'b0;
    `CHK("reg_start", exp_reg, {overrange_bit, result_data_bus_out})
    n = 0;
    while (busy_n !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    if (busy_n !== 1'b1) begin
      $display("ERROR busy_wait exp %h got %h", 1'b1, busy_n);
      err_total++;
      print_verdict;
    end
    if (!run) return;
    // n misses the release tick after the taking clock, so the low time is n + 1
    `CHK("busy_len", CONV + 2 - int'(interface_variant_sel_b), n + 1)
    pend_ok = interface_variant_sel_b;
    pend = exp_res;
    if (!interface_variant_sel_b) exp_reg = exp_res;
    `CHK("reg_done", exp_reg, {overrange_bit, result_data_bus_out})
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    #1 reset_n = 1'b1;
    tick;
    `CHK("busy_rst", 1'b1, busy_n)
    `CHK("offset_rst", 12'h000, offset_word)
    rd(1'b1);
    wr(1'b1, 12'h5a5);
    wr(1'b0, 12'h3c7);
    $display("test offset done");
    conv(1'b1);
    rd(1'b0);
    $display("test variant 1 done");
    interface_variant_sel_b = 1'b1;
    repeat (3) conv(1'b1);
    rd(1'b0);
    $display("test variant 2 done");
    for (int i = 0; i < 2; i++) begin
      {standby_request, light_sleep_request} = i ? 2'b01 : 2'b10;
      tick;
      `CHK("power", {standby_request, light_sleep_request}, {standby_active, nap_active})
      conv(1'b0);
    end
    {standby_request, light_sleep_request} = 2'b00;
    $display("test power done");
    conversion_start_n = 1'b0;
    tick;
    conversion_start_n = 1'b1;
    repeat (2) tick;
    reset_n = 1'b0;
    tick;
    reset_n = 1'b1;
    tick;
    `CHK("busy_abort", 1'b1, busy_n)
    `CHK("offset_clr", 12'h000, offset_word)
    exp_reg = 13'h0000;
    rd(1'b0);
    $display("test reset abort done");
    print_verdict;
  end
endmodule
